// ### verilog/ifm_ipv4_ace_field_matcher.sv
// Functional notes
// [R1] IPv4 criteria apply only when the entry's frame type is IPv4.
// [R2] Protocol don't-care ignores the IPv4 protocol number.
// [R3] Protocol specific: frame protocol must equal the 8-bit value.
// [R4] ICMP, UDP, TCP choices match that protocol and enable its criteria.
// [R5] TTL zero: frames with TTL above zero never hit.
// [R6] TTL non-zero: frames with TTL above zero may hit.
// [R7] Fragment No: more-fragments or nonzero offset frames never hit.
// [R8] Fragment Yes: fragmented frames may hit.
// [R9] Options No: frames with options never hit.
// [R10] Options Yes: frames with options may hit.
// [R11] TTL, fragment and options each have a don't-care setting.
// [R12] Source don't-care ignores the source address.
// [R13] Source host compares all 32 source address bits.
// [R14] Source network compares source address under a mask.
// [R15] Destination don't-care ignores the destination address.
// [R16] Destination host compares all 32 destination address bits.
// [R17] Destination network compares destination address under a mask.
// [R18] Network: masked frame equals masked config; host: full equality.
// [R19] Hit only when every enabled criterion matches; don't-care matches.
`default_nettype none
module ifm_ipv4_ace_field_matcher #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire ifm_pkg::ifm_hdr_type    hdr,
  output ifm_pkg::ifm_result_type      res
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ifm_pkg::ifm_apb_state_type st_q;
  ifm_pkg::ifm_apb_state_type st_d;
  logic [31:0]                prdata_q;
  logic [31:0]                prdata_d;
  logic                       pready_q;
  logic                       pready_d;
  logic                       pslverr_q;
  logic                       pslverr_d;
  logic                       wr_en;
  logic [2:0]                 idx;
  logic [31:0]                cfg_q [ifm_pkg::NUM_CFG];
  logic [31:0]                cfg_d [ifm_pkg::NUM_CFG];
  logic [CNT_W-1:0]           cnt_q;
  logic [CNT_W-1:0]           cnt_d;
  logic                       seen_q;
  logic                       seen_d;
  ifm_pkg::ifm_result_type    res_q;
  ifm_pkg::ifm_result_type    res_d;
  logic [31:0]                ctrl;
  logic [31:0]                status_word;
  logic [2:0]                 ftype;
  logic [2:0]                 pmode;
  logic [1:0]                 ttl_mode;
  logic [1:0]                 frag_mode;
  logic [1:0]                 opt_mode;
  logic [1:0]                 src_mode;
  logic [1:0]                 dst_mode;
  logic [7:0]                 proto_val;
  logic                       ipv4_sel;
  logic                       proto_ok;
  logic                       ttl_ok;
  logic                       frag_ok;
  logic                       opt_ok;
  logic                       src_ok;
  logic                       dst_ok;
  logic                       fragmented;
  logic                       has_options;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait state, answers in the first access cycle
  assign idx = ifm_pkg::reg_index(paddr);

  always_comb begin
    st_d      = st_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    wr_en     = 1'b0;
    unique case (st_q)
      ifm_pkg::ST_IDLE: begin
        if (psel && !penable) begin
          st_d      = ifm_pkg::ST_ACCESS;
          pready_d  = 1'b1;
          pslverr_d = (idx == ifm_pkg::IDX_NONE);
          if (idx == ifm_pkg::IDX_NONE || pwrite) begin
            prdata_d = 32'h0000_0000;
          end else if (idx == ifm_pkg::IDX_STATUS) begin
            prdata_d = status_word;
          end else begin
            prdata_d = cfg_q[idx];
          end
        end
      end
      ifm_pkg::ST_ACCESS: begin
        // Write lands only on the completing edge
        if (psel && penable && pready_q) begin
          st_d  = ifm_pkg::ST_IDLE;
          wr_en = pwrite && (idx != ifm_pkg::IDX_NONE);
        end else begin
          pready_d  = pready_q;
          pslverr_d = pslverr_q;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ifm_pkg::ST_IDLE;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, flops addressed by index
  always_comb begin
    for (int i = 0; i < ifm_pkg::NUM_CFG; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (wr_en && idx != ifm_pkg::IDX_STATUS) begin
      cfg_d[idx] = ifm_pkg::merge_strb(cfg_q[idx], pwdata, pstrb);
    end
    // Reserved bits stay zero so they read back as zero
    cfg_d[ifm_pkg::IDX_CTRL]  = cfg_d[ifm_pkg::IDX_CTRL] &
                                ifm_pkg::CTRL_MASK;
    cfg_d[ifm_pkg::IDX_PROTO] = cfg_d[ifm_pkg::IDX_PROTO] &
                                ifm_pkg::PROTO_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ifm_pkg::NUM_CFG; i++) begin
        cfg_q[i] <= ifm_pkg::CFG_RST;
      end
    end else begin
      for (int i = 0; i < ifm_pkg::NUM_CFG; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign ctrl      = cfg_q[ifm_pkg::IDX_CTRL];
  assign ftype     = ctrl[ifm_pkg::FT_POS +: 3];
  assign pmode     = ctrl[ifm_pkg::PM_POS +: 3];
  assign ttl_mode  = ctrl[ifm_pkg::TTL_POS +: 2];
  assign frag_mode = ctrl[ifm_pkg::FRAG_POS +: 2];
  assign opt_mode  = ctrl[ifm_pkg::OPT_POS +: 2];
  assign src_mode  = ctrl[ifm_pkg::SRC_POS +: 2];
  assign dst_mode  = ctrl[ifm_pkg::DST_POS +: 2];
  assign proto_val = cfg_q[ifm_pkg::IDX_PROTO][7:0];

  assign status_word = {cfg_cnt_ext(cnt_q), 14'h0000, seen_q,
                        res_q.entry_hit};

  function automatic logic [15:0] cfg_cnt_ext(input logic [CNT_W-1:0] c);
    logic [31:0] w;
    w = 32'(c);
    return w[15:0];
  endfunction : cfg_cnt_ext

  ////////////////////////////////////////////////////////////////////////////
  // Criteria
  assign ipv4_sel = hdr.valid && hdr.is_ipv4 &&
                    (ftype == ifm_pkg::FT_IPV4); // [R1]

  always_comb begin
    unique case (pmode)
      ifm_pkg::PM_ANY:      proto_ok = 1'b1; // [R2]
      ifm_pkg::PM_SPECIFIC: proto_ok = (hdr.protocol == proto_val); // [R3]
      ifm_pkg::PM_ICMP:     proto_ok = (hdr.protocol ==
                                        ifm_pkg::IPPROTO_ICMP); // [R4]
      ifm_pkg::PM_UDP:      proto_ok = (hdr.protocol ==
                                        ifm_pkg::IPPROTO_UDP); // [R4]
      ifm_pkg::PM_TCP:      proto_ok = (hdr.protocol ==
                                        ifm_pkg::IPPROTO_TCP); // [R4]
      // Undefined codes never hit, safer than matching all
      default:              proto_ok = 1'b0;
    endcase
  end

  assign fragmented  = hdr.more_fragments_flag ||
                       (hdr.fragment_offset_field != 13'h0000);
  assign has_options = (hdr.header_len > ifm_pkg::IHL_NO_OPT);

  ifm_tri_crit u_ttl (
    .mode    (ttl_mode),
    .present (hdr.ttl != 8'h00),
    .ok      (ttl_ok)
  ); // [R5] [R6] [R11]

  ifm_tri_crit u_frag (
    .mode    (frag_mode),
    .present (fragmented),
    .ok      (frag_ok)
  ); // [R7] [R8] [R11]

  ifm_tri_crit u_opt (
    .mode    (opt_mode),
    .present (has_options),
    .ok      (opt_ok)
  ); // [R9] [R10] [R11]

  ifm_addr_crit #(
    .AW (32)
  ) u_src (
    .mode       (src_mode),
    .frame_addr (hdr.source_ip),
    .cfg_addr   (cfg_q[ifm_pkg::IDX_SRC_ADDR]),
    .cfg_mask   (cfg_q[ifm_pkg::IDX_SRC_MASK]),
    .ok         (src_ok)
  ); // [R12] [R13] [R14] [R18]

  ifm_addr_crit #(
    .AW (32)
  ) u_dst (
    .mode       (dst_mode),
    .frame_addr (hdr.destination_ip),
    .cfg_addr   (cfg_q[ifm_pkg::IDX_DST_ADDR]),
    .cfg_mask   (cfg_q[ifm_pkg::IDX_DST_MASK]),
    .ok         (dst_ok)
  ); // [R15] [R16] [R17] [R18]

  ////////////////////////////////////////////////////////////////////////////
  // Result stage, one cycle after the header
  always_comb begin
    res_d.hit_valid      = hdr.valid;
    res_d.entry_hit      = ipv4_sel && proto_ok && ttl_ok && frag_ok &&
                           opt_ok && src_ok && dst_ok; // [R19]
    res_d.icmp_params_en = (ftype == ifm_pkg::FT_IPV4) &&
                           (pmode == ifm_pkg::PM_ICMP); // [R4]
    res_d.udp_params_en  = (ftype == ifm_pkg::FT_IPV4) &&
                           (pmode == ifm_pkg::PM_UDP); // [R4]
    res_d.tcp_params_en  = (ftype == ifm_pkg::FT_IPV4) &&
                           (pmode == ifm_pkg::PM_TCP); // [R4]
    seen_d = seen_q || hdr.valid;
    cnt_d  = cnt_q;
    if (wr_en && idx == ifm_pkg::IDX_STATUS) begin
      seen_d = hdr.valid;
      cnt_d  = '0;
    end
    // A hit in the clearing cycle still counts
    if (res_d.entry_hit) begin
      cnt_d = cnt_d + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q  <= '0;
      cnt_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      res_q  <= res_d;
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign res     = res_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_hit_needs_ipv4: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    res_q.entry_hit |-> $past(ipv4_sel))
    else $error("hit without IPv4 entry and frame");

  a_proto_value: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && pmode == ifm_pkg::PM_SPECIFIC && hdr.protocol != proto_val
    |=> !res_q.entry_hit)
    else $error("protocol mismatch still hit");

  a_ttl_zero: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && ttl_mode == ifm_pkg::TRI_NO && hdr.ttl != 8'h00
    |=> !res_q.entry_hit)
    else $error("nonzero ttl hit a zero-ttl entry");

  a_frag_no: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && frag_mode == ifm_pkg::TRI_NO &&
    (hdr.more_fragments_flag || hdr.fragment_offset_field != 13'h0000)
    |=> !res_q.entry_hit)
    else $error("fragment hit a no-fragment entry");

  a_opt_no: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && opt_mode == ifm_pkg::TRI_NO && hdr.header_len > 4'h5
    |=> !res_q.entry_hit)
    else $error("options frame hit a no-options entry");

  a_src_host: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && src_mode == ifm_pkg::AM_HOST &&
    hdr.source_ip != cfg_q[ifm_pkg::IDX_SRC_ADDR]
    |=> !res_q.entry_hit)
    else $error("source host mismatch still hit");

  a_dst_network: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && dst_mode == ifm_pkg::AM_NETWORK &&
    ((hdr.destination_ip ^ cfg_q[ifm_pkg::IDX_DST_ADDR]) &
     cfg_q[ifm_pkg::IDX_DST_MASK]) != 32'h0000_0000
    |=> !res_q.entry_hit)
    else $error("destination network mismatch still hit");

  a_all_any_hit: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    ipv4_sel && ctrl[17:4] == 14'h0000 |=> res_q.entry_hit)
    else $error("all don't-care entry missed an IPv4 frame");

  a_pready_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && st_q == ifm_pkg::ST_IDLE
    |=> pready_q ##1 !pready_q)
    else $error("pready not a single access cycle");

endmodule : ifm_ipv4_ace_field_matcher

`default_nettype wire

// ### verilog/ifm_pkg.sv
`default_nettype none

package ifm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int unsigned     ADDR_W       = 8;
  localparam int unsigned     DATA_W       = 32;
  localparam int unsigned     NUM_CFG      = 6;
  localparam int unsigned     IDX_W        = 3;

  localparam logic [7:0]      OFF_CTRL     = 8'h00;
  localparam logic [7:0]      OFF_PROTO    = 8'h04;
  localparam logic [7:0]      OFF_SRC_ADDR = 8'h08;
  localparam logic [7:0]      OFF_SRC_MASK = 8'h0C;
  localparam logic [7:0]      OFF_DST_ADDR = 8'h10;
  localparam logic [7:0]      OFF_DST_MASK = 8'h14;
  localparam logic [7:0]      OFF_STATUS   = 8'h18;

  localparam logic [2:0]      IDX_CTRL     = 3'h0;
  localparam logic [2:0]      IDX_PROTO    = 3'h1;
  localparam logic [2:0]      IDX_SRC_ADDR = 3'h2;
  localparam logic [2:0]      IDX_SRC_MASK = 3'h3;
  localparam logic [2:0]      IDX_DST_ADDR = 3'h4;
  localparam logic [2:0]      IDX_DST_MASK = 3'h5;
  localparam logic [2:0]      IDX_STATUS   = 3'h6;
  localparam logic [2:0]      IDX_NONE     = 3'h7;

  // Writable bits per register; everything else reads as zero
  localparam logic [31:0]     CTRL_MASK    = 32'h0003_FF77;
  localparam logic [31:0]     PROTO_MASK   = 32'h0000_00FF;
  localparam logic [31:0]     CFG_RST      = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned     FT_POS       = 0;
  localparam int unsigned     PM_POS       = 4;
  localparam int unsigned     TTL_POS      = 8;
  localparam int unsigned     FRAG_POS     = 10;
  localparam int unsigned     OPT_POS      = 12;
  localparam int unsigned     SRC_POS      = 14;
  localparam int unsigned     DST_POS      = 16;
  localparam int unsigned     STAT_CNT_POS = 16;

  localparam logic [2:0]      FT_ANY       = 3'h0;
  localparam logic [2:0]      FT_IPV4      = 3'h3;

  localparam logic [2:0]      PM_ANY       = 3'h0;
  localparam logic [2:0]      PM_SPECIFIC  = 3'h1;
  localparam logic [2:0]      PM_ICMP      = 3'h2;
  localparam logic [2:0]      PM_UDP       = 3'h3;
  localparam logic [2:0]      PM_TCP       = 3'h4;

  // Tri-state criteria: any / zero-or-no / nonzero-or-yes
  localparam logic [1:0]      TRI_ANY      = 2'h0;
  localparam logic [1:0]      TRI_NO       = 2'h1;
  localparam logic [1:0]      TRI_YES      = 2'h2;

  localparam logic [1:0]      AM_ANY       = 2'h0;
  localparam logic [1:0]      AM_HOST      = 2'h1;
  localparam logic [1:0]      AM_NETWORK   = 2'h2;

  localparam logic [7:0]      IPPROTO_ICMP = 8'h01;
  localparam logic [7:0]      IPPROTO_TCP  = 8'h06;
  localparam logic [7:0]      IPPROTO_UDP  = 8'h11;
  localparam logic [3:0]      IHL_NO_OPT   = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        is_ipv4;
    logic [7:0]  protocol;
    logic [7:0]  ttl;
    logic        more_fragments_flag;
    logic [12:0] fragment_offset_field;
    logic [3:0]  header_len;
    logic [31:0] source_ip;
    logic [31:0] destination_ip;
  } ifm_hdr_type;

  typedef struct packed {
    logic hit_valid;
    logic entry_hit;
    logic icmp_params_en;
    logic udp_params_en;
    logic tcp_params_en;
  } ifm_result_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } ifm_apb_state_type;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    logic [2:0] idx;
    unique case (addr)
      OFF_CTRL:     idx = IDX_CTRL;
      OFF_PROTO:    idx = IDX_PROTO;
      OFF_SRC_ADDR: idx = IDX_SRC_ADDR;
      OFF_SRC_MASK: idx = IDX_SRC_MASK;
      OFF_DST_ADDR: idx = IDX_DST_ADDR;
      OFF_DST_MASK: idx = IDX_DST_MASK;
      OFF_STATUS:   idx = IDX_STATUS;
      default:      idx = IDX_NONE;
    endcase
    return idx;
  endfunction : reg_index

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_strb

endpackage : ifm_pkg

`default_nettype wire

// ### verilog/ifm_tri_crit.sv
`default_nettype none

module ifm_tri_crit (
  input  wire logic [1:0] mode,
  input  wire logic       present,
  output logic            ok
);

  // Reserved code 3 behaves as don't-care
  always_comb begin
    unique case (mode)
      ifm_pkg::TRI_NO:  ok = !present;
      ifm_pkg::TRI_YES: ok = present;
      default:          ok = 1'b1;
    endcase
  end

endmodule : ifm_tri_crit

`default_nettype wire

// ### verilog/ifm_addr_crit.sv
`default_nettype none

module ifm_addr_crit #(
  parameter int unsigned AW = 32
) (
  input  wire logic [1:0]    mode,
  input  wire logic [AW-1:0] frame_addr,
  input  wire logic [AW-1:0] cfg_addr,
  input  wire logic [AW-1:0] cfg_mask,
  output logic               ok
);

  // Reserved code 3 behaves as don't-care
  always_comb begin
    unique case (mode)
      ifm_pkg::AM_HOST:    ok = (frame_addr == cfg_addr);
      ifm_pkg::AM_NETWORK: ok = ((frame_addr & cfg_mask) ==
                                 (cfg_addr & cfg_mask));
      default:             ok = 1'b1;
    endcase
  end

endmodule : ifm_addr_crit

`default_nettype wire

// ### bench/ifm_hdr_src.sv
`default_nettype none

module ifm_hdr_src (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 go,
  input  wire ifm_pkg::ifm_hdr_type fields,
  output var  ifm_pkg::ifm_hdr_type hdr
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HW = $bits(ifm_pkg::ifm_hdr_type);

  logic [HW-2:0] junk_q;
  logic [HW-2:0] junk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Idle fields toggle each cycle, so a stale header never matches by luck
  always_comb begin
    junk_d = ~junk_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      junk_q <= '0;
    end else begin
      junk_q <= junk_d;
    end
  end

  // Valid is the top bit; one header per cycle while go is high
  assign hdr = go ? {1'b1, fields[HW-2:0]} : {1'b0, junk_q};

endmodule : ifm_hdr_src

`default_nettype wire

// ### bench/ifm_ipv4_ace_field_matcher_test.sv
`default_nettype none

module ifm_ipv4_ace_field_matcher_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  PV = 8'hFF;
  localparam logic [31:0] SA = 32'hC0A8_0105;
  localparam logic [31:0] SM = 32'hFFFF_FF00;
  localparam logic [31:0] DA = 32'h0A00_00FF;
  localparam logic [31:0] DM = 32'hFF00_0000;

  logic                 pclk, presetn, psel, penable, pwrite, go;
  logic                 pready, pslverr, er, e, last;
  logic [7:0]           paddr;
  logic [3:0]           pstrb;
  logic [31:0]          pwdata, prdata, rd, c;
  ifm_pkg::ifm_hdr_type hdr, fields;
  ifm_pkg::ifm_result_type res;
  int                   num_errors, compares, cnt;

  ifm_ipv4_ace_field_matcher i_ifm_ipv4_ace_field_matcher (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hdr(hdr),
    .res(res));

  ifm_hdr_src i_ifm_hdr_src (
    .pclk(pclk), .presetn(presetn), .go(go), .fields(fields), .hdr(hdr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run at once
    if (n >= 50) begin
      chk(1'b0, 1'b1, "apb timeout");
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  function automatic ifm_pkg::ifm_hdr_type vh(input int v);
    case (v)
      1: return '{1'b1, 1'b1, 8'h11, 8'h00, 1'b0, 13'h0000, 4'h5,
                  32'hC0A8_0177, 32'h0B00_0001};
      2: return '{1'b1, 1'b1, 8'h01, 8'h01, 1'b1, 13'h0000, 4'h6,
                  32'hC0A9_0105, 32'h0A00_00FF};
      3: return '{1'b1, 1'b1, 8'hFF, 8'hFF, 1'b0, 13'h1FFF, 4'hF,
                  32'hC0A8_0105, 32'h0A00_00FF};
      default: return '{1'b1, v != 4, 8'h06, 8'h40, 1'b0, 13'h0000, 4'h5,
                        32'hC0A8_0105, 32'h0A00_0001};
    endcase
  endfunction : vh

  function automatic logic tri_ok(input logic [1:0] m, input logic p);
    return (m == 2'h1) ? !p : (m == 2'h2) ? p : 1'b1;
  endfunction : tri_ok

  function automatic logic adr_ok(input logic [1:0] m,
                                  input logic [31:0] f, a, k);
    return (m == 2'h1) ? f == a : (m == 2'h2) ? (f & k) == (a & k) : 1'b1;
  endfunction : adr_ok

  // Reference decision, written from the criteria, not from the design
  function automatic logic ref_hit(input logic [31:0] c,
                                   input ifm_pkg::ifm_hdr_type h);
    logic ok;
    ok = h.is_ipv4 && c[2:0] == 3'h3;
    case (c[6:4])
      3'h0: ok = ok;
      3'h1: ok &= h.protocol == PV;
      3'h2: ok &= h.protocol == ifm_pkg::IPPROTO_ICMP;
      3'h3: ok &= h.protocol == ifm_pkg::IPPROTO_UDP;
      3'h4: ok &= h.protocol == ifm_pkg::IPPROTO_TCP;
      default: ok = 1'b0;
    endcase
    ok &= tri_ok(c[9:8], h.ttl != 8'h00);
    ok &= tri_ok(c[11:10],
                 h.more_fragments_flag || h.fragment_offset_field != 0);
    ok &= tri_ok(c[13:12], h.header_len > 4'h5);
    ok &= adr_ok(c[15:14], h.source_ip, SA, SM);
    ok &= adr_ok(c[17:16], h.destination_ip, DA, DM);
    return ok;
  endfunction : ref_hit

  function automatic logic [31:0] cfg(input int f, input int m);
    int pos[6] = '{4, 8, 10, 12, 14, 16};
    if (f == 6) return 32'(m);
    if (f == 7) return 32'h0002_9603;
    return 32'h3 | (32'(m) << pos[f]);
  endfunction : cfg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    go = 1'b0;
    fields = '0;
    cnt = 0;
    last = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h18; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, 4'h0);
      chk(rd, 32'h0, "reset value");
      chk(er, 1'b0, "mapped read error");
    end
    apb(1'b0, 8'h1C, 32'h0, 4'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    chk(er, 1'b1, "unmapped write");
    apb(1'b1, ifm_pkg::OFF_SRC_ADDR, 32'hFFFF_FFFF, 4'h2);
    apb(1'b0, ifm_pkg::OFF_SRC_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_FF00, "strobe merge");
    apb(1'b1, ifm_pkg::OFF_CTRL, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, ifm_pkg::OFF_CTRL, 32'h0, 4'h0);
    chk(rd, ifm_pkg::CTRL_MASK, "ctrl reserved");
    apb(1'b1, ifm_pkg::OFF_PROTO, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, ifm_pkg::OFF_PROTO, 32'h0, 4'h0);
    chk(rd, 32'(PV), "proto reserved");
    apb(1'b1, ifm_pkg::OFF_SRC_ADDR, SA, 4'hF);
    apb(1'b1, ifm_pkg::OFF_SRC_MASK, SM, 4'hF);
    apb(1'b1, ifm_pkg::OFF_DST_ADDR, DA, 4'hF);
    apb(1'b1, ifm_pkg::OFF_DST_MASK, DM, 4'hF);
    apb(1'b1, ifm_pkg::OFF_STATUS, 32'h0, 4'hF);
    // Sweep one criterion at a time, then TTL, fragment, options and both addresses together
    for (int f = 0; f < 8; f++) begin
      for (int m = 0; m < 8; m++) begin
        if ((f == 0 || f == 6 || m < 4) && (f < 7 || m == 0)) begin
          c = cfg(f, m);
          apb(1'b1, ifm_pkg::OFF_CTRL, c, 4'hF);
          @(posedge pclk);
          #1;
          e = c[2:0] == 3'h3;
          chk(res.icmp_params_en, e && c[6:4] == 3'h2, "icmp en");
          chk(res.udp_params_en, e && c[6:4] == 3'h3, "udp en");
          chk(res.tcp_params_en, e && c[6:4] == 3'h4, "tcp en");
          // Back-to-back headers, each answer one cycle later
          for (int t = 0; t <= 5; t++) begin
            @(posedge pclk);
            go <= (t < 5);
            fields <= vh(t % 5);
            #1;
            if (t > 0) begin
              e = ref_hit(c, vh(t - 1));
              cnt += int'(e);
              last = e;
              chk(res.hit_valid, 1'b1, "hit valid");
              chk(res.entry_hit, e, "entry hit");
            end
          end
        end
      end
    end
    apb(1'b0, ifm_pkg::OFF_STATUS, 32'h0, 4'h0);
    chk(rd, {16'(cnt), 14'h0, 1'b1, last}, "hit status");
    wrap_up();
  end

endmodule : ifm_ipv4_ace_field_matcher_test

`default_nettype wire
